// File: src/pss_pkg.sv
package pss_pkg;

  // ----------------------------------------
  // register map (printed offsets are not word aligned: kept as indices)
  // ----------------------------------------
  localparam logic [7:0] PSS_IDX_POINTER_SELECT = 8'h86;
  localparam logic [7:0] PSS_IDX_STROBE_TIMING = 8'h8E;
  localparam logic [7:0] PSS_IDX_FIRST_PTR = 8'hA0;
  localparam logic [7:0] PSS_IDX_SECOND_PTR = 8'hA1;
  localparam logic [7:0] PSS_IDX_CORE_CMD = 8'hA2;
  localparam logic [7:0] PSS_IDX_CORE_STATUS = 8'hA3;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PSS_SEL_BIT = 0;
  localparam int PSS_FLIP_BIT = 5;
  localparam int PSS_DIR0_BIT = 6;
  localparam int PSS_DIR1_BIT = 7;
  localparam int PSS_STRETCH_LSB = 0;
  localparam int PSS_STRETCH_MSB = 2;
  localparam int PSS_WD_LSB = 6;
  localparam int PSS_WD_MSB = 7;
  localparam int PSS_CMD_OP_LSB = 0;
  localparam int PSS_CMD_OP_MSB = 2;
  localparam int PSS_CMD_DATA_LSB = 8;
  localparam int PSS_CMD_DATA_MSB = 23;

  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [7:0] PSS_POINTER_SELECT_RST = 8'h00;
  localparam logic [7:0] PSS_STROBE_TIMING_RST = 8'h07;
  localparam logic [15:0] PSS_PTR_RST = 16'h0000;
  localparam logic [2:0] PSS_STRETCH_MIN = 3'h2;

  // ----------------------------------------
  // pointer instructions
  // ----------------------------------------
  typedef enum logic [2:0] {
    PSS_OP_NONE = 3'b000,
    PSS_OP_XSTORE = 3'b001,
    PSS_OP_XLOAD = 3'b010,
    PSS_OP_TABLE_READ = 3'b011,
    PSS_OP_INDEXED_JUMP = 3'b100,
    PSS_OP_PTR_INC = 3'b101,
    PSS_OP_PTR_LOAD = 3'b110
  } pss_op_t;

  typedef struct packed {
    pss_op_t op;
    logic [15:0] data;
  } pss_cmd_t;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic [15:0] addr;
  } pss_strobe_t;

endpackage

// File: src/pss_strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pss_strobe_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_read,
  input wire logic [2:0] stretch,
  output logic busy,
  output logic rd_active,
  output logic wr_active
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic rd_reg;
  logic rd_next;

  // ----------------------------------------
  // pulse counter
  // ----------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    rd_next = rd_reg;
    if (busy_reg) begin
      if (cnt_reg == 3'h0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 3'h1;
      end
    end else if (start) begin
      busy_next = 1'b1;
      rd_next = is_read;
      // width is stretch + 1 clocks, clamped to 3..8
      if (stretch < pss_pkg::PSS_STRETCH_MIN) begin
        cnt_next = pss_pkg::PSS_STRETCH_MIN;
      end else begin
        cnt_next = stretch;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
      busy_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      rd_reg <= rd_next;
    end
  end

  assign busy = busy_reg;
  assign rd_active = busy_reg && rd_reg;
  assign wr_active = busy_reg && !rd_reg;

endmodule

`default_nettype wire

// File: src/pss_top.sv
// Overview of operation
// - select bit zero picks first pointer
// - auto flip inverts select after pointer instructions
// - stretch field sets strobe pulse width
// - strobes active only during external moves
// - reset loads stretch field with seven
// - pulse width equals stretch plus one
// - pulse width kept between three and eight
// - new stretch applies to next access
`timescale 1ns/1ps
`default_nettype none

module pss_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pss_pkg::pss_strobe_t strobe,
  output logic [15:0] active_data_pointer
);

  logic [7:0] pointer_select_control_reg;
  logic [7:0] pointer_select_control_next;
  logic [7:0] strobe_timing_control_reg;
  logic [7:0] strobe_timing_control_next;
  logic [15:0] first_data_pointer_reg;
  logic [15:0] first_data_pointer_next;
  logic [15:0] second_data_pointer_reg;
  logic [15:0] second_data_pointer_next;
  pss_pkg::pss_strobe_t strobe_reg;
  pss_pkg::pss_strobe_t strobe_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic err_next;
  logic err_reg;
  pss_pkg::pss_cmd_t cmd;
  logic wr_acc;
  logic rd_acc;
  logic cmd_go;
  logic sel;
  logic [15:0] cur_ptr;
  logic [15:0] ptr_upd;
  logic xmove;
  logic busy;
  logic rd_active;
  logic wr_active;
  logic [9:0] widx;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign widx = paddr[11:2];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign cmd.op = pss_pkg::pss_op_t'(pwdata[pss_pkg::PSS_CMD_OP_MSB:pss_pkg::PSS_CMD_OP_LSB]);
  assign cmd.data = pwdata[pss_pkg::PSS_CMD_DATA_MSB:pss_pkg::PSS_CMD_DATA_LSB];
  // a command is held off while a strobe is running
  assign pready = !(psel && penable && pwrite && busy
                    && widx == {2'b00, pss_pkg::PSS_IDX_CORE_CMD});
  assign cmd_go = wr_acc && pready && widx == {2'b00, pss_pkg::PSS_IDX_CORE_CMD}
                  && cmd.op != pss_pkg::PSS_OP_NONE;
  assign xmove = cmd.op == pss_pkg::PSS_OP_XSTORE || cmd.op == pss_pkg::PSS_OP_XLOAD;

  // ----------------------------------------
  // pointer selection
  // ----------------------------------------
  assign sel = pointer_select_control_reg[pss_pkg::PSS_SEL_BIT];
  assign cur_ptr = sel ? second_data_pointer_reg : first_data_pointer_reg;
  assign active_data_pointer = cur_ptr;

  always_comb begin
    ptr_upd = cur_ptr;
    if (cmd.op == pss_pkg::PSS_OP_PTR_INC) begin
      ptr_upd = cur_ptr + 16'h0001;
    end else if (cmd.op == pss_pkg::PSS_OP_PTR_LOAD) begin
      ptr_upd = cmd.data;
    end
  end

  always_comb begin
    pointer_select_control_next = pointer_select_control_reg;
    strobe_timing_control_next = strobe_timing_control_reg;
    first_data_pointer_next = first_data_pointer_reg;
    second_data_pointer_next = second_data_pointer_reg;
    if (wr_acc) begin
      if (widx == {2'b00, pss_pkg::PSS_IDX_POINTER_SELECT}) begin
        pointer_select_control_next = {pwdata[7:5], 4'h0, pwdata[0]};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_STROBE_TIMING}) begin
        // takes effect at the next access start
        strobe_timing_control_next = {pwdata[7:6], 3'h0, pwdata[2:0]};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_FIRST_PTR}) begin
        first_data_pointer_next = pwdata[15:0];
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_SECOND_PTR}) begin
        second_data_pointer_next = pwdata[15:0];
      end
    end
    if (cmd_go) begin
      if (sel) begin
        second_data_pointer_next = ptr_upd;
      end else begin
        first_data_pointer_next = ptr_upd;
      end
      if (pointer_select_control_reg[pss_pkg::PSS_FLIP_BIT]) begin
        pointer_select_control_next[pss_pkg::PSS_SEL_BIT] = !sel;
      end
    end
  end

  // ----------------------------------------
  // strobe generation
  // ----------------------------------------
  pss_strobe_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(cmd_go && xmove),
    .is_read(cmd.op == pss_pkg::PSS_OP_XLOAD),
    .stretch(strobe_timing_control_reg[pss_pkg::PSS_STRETCH_MSB:pss_pkg::PSS_STRETCH_LSB]),
    .busy(busy),
    .rd_active(rd_active),
    .wr_active(wr_active)
  );

  always_comb begin
    strobe_next = strobe_reg;
    strobe_next.rd_n = !rd_active;
    strobe_next.wr_n = !wr_active;
    if (cmd_go && xmove) begin
      strobe_next.addr = cur_ptr;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    prdata_next = prdata_reg;
    err_next = 1'b0;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      if (widx == {2'b00, pss_pkg::PSS_IDX_POINTER_SELECT}) begin
        prdata_next = {24'h00_0000, pointer_select_control_reg};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_STROBE_TIMING}) begin
        prdata_next = {24'h00_0000, strobe_timing_control_reg};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_FIRST_PTR}) begin
        prdata_next = {16'h0000, first_data_pointer_reg};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_SECOND_PTR}) begin
        prdata_next = {16'h0000, second_data_pointer_reg};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_CORE_STATUS}) begin
        prdata_next = {29'h0000_0000, wr_active, rd_active, busy};
      end else if (widx == {2'b00, pss_pkg::PSS_IDX_CORE_CMD}) begin
        prdata_next = 32'h0000_0000;
      end else begin
        err_next = 1'b1;
      end
    end else if (psel && penable) begin
      err_next = err_reg;
    end
  end

  assign prdata = rd_acc ? prdata_reg : 32'h0000_0000;
  assign pslverr = psel && penable && err_reg;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_select_control_reg <= pss_pkg::PSS_POINTER_SELECT_RST;
      strobe_timing_control_reg <= pss_pkg::PSS_STROBE_TIMING_RST;
      first_data_pointer_reg <= pss_pkg::PSS_PTR_RST;
      second_data_pointer_reg <= pss_pkg::PSS_PTR_RST;
      strobe_reg <= '{rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000};
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      pointer_select_control_reg <= pointer_select_control_next;
      strobe_timing_control_reg <= strobe_timing_control_next;
      first_data_pointer_reg <= first_data_pointer_next;
      second_data_pointer_reg <= second_data_pointer_next;
      strobe_reg <= strobe_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign strobe = strobe_reg;

endmodule

`default_nettype wire

// File: test/pss_slow_ram.sv
`timescale 1ns/1ps
`default_nettype none
module pss_slow_ram (
  input wire logic pclk,
  input wire logic presetn,
  input wire pss_pkg::pss_strobe_t strobe,
  output logic [3:0] width,
  output logic [15:0] addr,
  output logic [7:0] nrd,
  output logic [7:0] nwr
);
  // ----
  // pulse measure, counted at pulse end
  // ----
  logic [3:0] run;
  logic rd;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
      rd <= 1'h0;
      width <= '0;
      addr <= '0;
      nrd <= '0;
      nwr <= '0;
    end else if (!strobe.rd_n || !strobe.wr_n) begin
      run <= run + 4'h1;
      rd <= !strobe.rd_n;
      addr <= strobe.addr;
    end else if (run != 4'h0) begin
      width <= run;
      run <= '0;
      nrd <= nrd + {7'h0, rd};
      nwr <= nwr + {7'h0, !rd};
    end
  end
endmodule
`default_nettype wire

// File: test/pss_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pss_top_bench;
  localparam logic [7:0] SEL_R = pss_pkg::PSS_IDX_POINTER_SELECT;
  localparam logic [7:0] TIM_R = pss_pkg::PSS_IDX_STROBE_TIMING;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, sel, flip;
  pss_pkg::pss_strobe_t strobe;
  logic [15:0] active_data_pointer, m_addr;
  logic [15:0] ptr [2];
  logic [3:0] m_width;
  logic [7:0] nrd, nwr;
  logic [2:0] cur;
  logic [2:0] nv [4] = '{3'h2, 3'h5, 3'h3, 3'h7};
  int err_count = 0, checks = 0, cyc = 0, npulse = 0;
  pss_top u_pss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strobe(strobe), .active_data_pointer(active_data_pointer));
  pss_slow_ram u_pss_slow_ram (.pclk(pclk), .presetn(presetn), .strobe(strobe),
    .width(m_width), .addr(m_addr), .nrd(nrd), .nwr(nwr));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      end_sim();
    end
  end
  // ----
  // bus tasks
  // ----
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    forever begin
      @(posedge pclk);
      if (pready === 1'h1) begin
        q = prdata;
        err = pslverr;
        break;
      end
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input logic [2:0] op);
    apb(1'h1, pss_pkg::PSS_IDX_CORE_CMD, {8'h00, 16'hBEE0, 5'h00, op});
    if (op == 3'h5) ptr[sel] = ptr[sel] + 16'h1;
    if (op == 3'h6) ptr[sel] = 16'hBEE0;
    if (op == 3'h1 || op == 3'h2) npulse++;
    if (op != 3'h0) sel = sel ^ flip;
    @(negedge pclk);
    `CHK("active_ptr", ptr[sel], active_data_pointer)
    apb(1'h0, SEL_R, '0);
    `CHK("select_bit", sel, q[0])
  endtask
  task automatic wait_pulses();
    for (int k = 0; k < 60 && int'(nrd) + int'(nwr) < npulse; k++) @(negedge pclk);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    sel = 1'h1;
    flip = 1'h0;
    ptr = '{16'h1234, 16'h5678};
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, SEL_R, '0);
    `CHK("select_reg", 32'h0, q)
    apb(1'h0, TIM_R, '0);
    `CHK("timing_reg", 32'h7, q)
    apb(1'h0, 8'h10, '0);
    `CHK("unmapped", 1'h1, err)
    apb(1'h1, pss_pkg::PSS_IDX_FIRST_PTR, 32'h1234);
    apb(1'h1, pss_pkg::PSS_IDX_SECOND_PTR, 32'h5678);
    apb(1'h1, SEL_R, 32'h1);
    cmd(3'h0);
    cmd(3'h5);
    apb(1'h1, SEL_R, 32'h20);
    sel = 1'h0;
    flip = 1'h1;
    for (int op = 1; op < 7; op++) cmd(3'(op));
    wait_pulses();
    `CHK("width_rst", 4'h8, m_width)
    apb(1'h1, SEL_R, '0);
    flip = 1'h0;
    cur = 3'h7;
    for (int i = 0; i < 4; i++) begin
      cmd(i[0] ? 3'h1 : 3'h2);
      if (i == 0) begin
        apb(1'h0, pss_pkg::PSS_IDX_CORE_STATUS, '0);
        `CHK("status_busy", 32'h3, q)
      end
      apb(1'h1, TIM_R, {29'h0, nv[i]});
      wait_pulses();
      `CHK("width", {1'h0, cur} + 4'h1, m_width)
      `CHK("addr", ptr[0], m_addr)
      cur = nv[i];
    end
    `CHK("reads", 8'h3, nrd)
    `CHK("writes", 8'h3, nwr)
    `CHK("idle", 2'h3, {strobe.rd_n, strobe.wr_n})
    apb(1'h0, pss_pkg::PSS_IDX_CORE_STATUS, '0);
    `CHK("status_idle", 32'h0, q)
    end_sim();
  end
endmodule
bind pss_top pss_top_chk u_pss_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .strobe(strobe),
  .active_data_pointer(active_data_pointer));
`default_nettype wire

// File: test/pss_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pss_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pss_pkg::pss_strobe_t strobe,
  input wire logic [15:0] active_data_pointer
);
  // ----
  // shadow of stretch and pulse length
  // ----
  logic act, acc, cmdw, timr;
  logic [3:0] cnt, ew;
  logic [7:0] tim;
  assign act = !(strobe.rd_n && strobe.wr_n);
  assign acc = psel && penable && pready && pwrite;
  assign cmdw = acc && paddr[11:2] == 10'(pss_pkg::PSS_IDX_CORE_CMD);
  assign timr = paddr[11:2] == 10'(pss_pkg::PSS_IDX_STROBE_TIMING);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      ew <= 4'h8;
      tim <= 8'h07;
    end else begin
      cnt <= act ? cnt + 4'h1 : 4'h0;
      if (acc && timr) begin
        tim <= {pwdata[7:6], 3'h0, pwdata[2:0]};
      end
      if (cmdw && (pwdata[2:0] == 3'h1 || pwdata[2:0] == 3'h2)) begin
        ew <= (tim[2:0] < 3'h2) ? 4'h3 : {1'h0, tim[2:0]} + 4'h1;
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pulse_width: assert property ($fell(act) |-> cnt == ew)
    else $error("strobe width off");
  a_width_ceiling: assert property (cnt <= 4'h8)
    else $error("strobe too long");
  a_width_floor: assert property ($fell(act) |-> cnt >= 4'h3)
    else $error("strobe too short");
  a_read_cause: assert property ($fell(strobe.rd_n) |-> $past(cmdw && pwdata[2:0] == 3'h2, 2))
    else $error("read strobe without load");
  a_write_cause: assert property ($fell(strobe.wr_n) |-> $past(cmdw && pwdata[2:0] == 3'h1, 2))
    else $error("write strobe without store");
  a_one_strobe: assert property (strobe.rd_n || strobe.wr_n)
    else $error("both strobes low");
  a_addr_hold: assert property (act && $past(act) |-> $stable(strobe.addr))
    else $error("address moved in pulse");
  a_stretch_read: assert property (psel && penable && !pwrite && timr |-> prdata == {24'h0, tim})
    else $error("timing register readback");
  c_read_pulse: cover property ($fell(strobe.rd_n));
  c_write_pulse: cover property ($fell(strobe.wr_n));
  c_cmd_stall: cover property (psel && penable && !pready);
endmodule
`default_nettype wire
